// ===== hdl/qcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "qcr_map.svh"

module qcr_regs
	import qcr_pkg::*;
#(
	parameter int NCH = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mpi_cs_n,
	input wire logic mpi_dclk,
	input wire logic mpi_din,
	output logic mpi_dout,
	output logic mpi_dout_oe,
	input wire logic [7:0] rt_inputs,
	input wire logic clock_fail_in,
	input wire logic mu_law_in,
	input wire logic e1_mux_enable,
	input wire logic ref_2048_tick,
	input wire logic [NCH-1:0][4:0] line_pin_in,
	output logic [NCH-1:0][4:0] line_pin_out,
	output logic [NCH-1:0][4:0] line_pin_oe,
	output logic [NCH-1:0][1:0] line_aux_out,
	output logic [NCH-1:0] line_io_1_second,
	output logic irq_n_out,
	output logic irq_n_oe,
	output qcr_chip_cfg_s chip_cfg,
	output logic chopper_tick,
	output logic [13:0] master_freq_khz,
	output logic master_freq_reserved,
	output logic e1_mux_allowed,
	output logic tx_launch_edge,
	output logic [2:0] rx_clock_slot,
	output logic [2:0] tx_clock_slot,
	output logic [NCH-1:0][6:0] rx_time_slot,
	output logic [NCH-1:0][6:0] tx_time_slot,
	output logic [NCH-1:0] tx_on_a,
	output logic [NCH-1:0] tx_on_b,
	output logic robbed_bit_active,
	output logic [NCH-1:0] analog_output_float,
	output logic [NCH-1:0] analog_output_to_ref,
	output qcr_gain_s [NCH-1:0] gain_cfg,
	output logic [NCH-1:0] full_digital_loopback,
	output logic [NCH-1:0] isn_cutoff,
	output logic [NCH-1:0] channel_active_flag,
	output logic clock_sync_lost
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [1:0] first_chan(input logic [NCH-1:0] en);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i]) begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction : first_chan

	function automatic logic is_wr_cmd(input logic [7:0] c);
		return (c == `QCR_CMD_TXTS) || (c == `QCR_CMD_RXTS) || (c == `QCR_CMD_SLOT) || (c == `QCR_CMD_CFG)
			|| (c == `QCR_CMD_CHEN) || (c == `QCR_CMD_GAIN) || (c == `QCR_CMD_IO) || (c == `QCR_CMD_DIR);
	endfunction : is_wr_cmd

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	qcr_state_e state;
	logic dclk_q;
	logic [2:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [7:0] cmd_q;
	logic [7:0] chen;
	logic tx_edge_q;
	logic [2:0] rx_cslot_q;
	logic [2:0] tx_cslot_q;
	logic [NCH-1:0] tab_q;
	logic [NCH-1:0] tx_hwy_q;
	logic [NCH-1:0] rpcm_q;
	logic [NCH-1:0][6:0] txts_q;
	logic [NCH-1:0][6:0] rxts_q;
	logic [NCH-1:0][7:0] io_q;
	logic [NCH-1:0][4:0] dir_q;
	logic [NCH-1:0] active_q;
	logic [7:0] rt_prev;
	logic irq_pending;
	logic [2:0] chop_cnt;

	logic rise;
	logic fall;
	logic [7:0] rx_byte;
	logic cmd_done;
	logic wr_done;
	logic [NCH-1:0] en;
	logic any_en;
	logic [1:0] sel;
	logic [7:0] rd_byte;
	logic rd_ok;

	assign rise = mpi_dclk & ~dclk_q;
	assign fall = ~mpi_dclk & dclk_q;
	assign rx_byte = {shift_in[6:0], mpi_din};
	assign cmd_done = !mpi_cs_n && rise && state == QCR_ST_CMD && bit_cnt == 3'h7;
	assign wr_done = !mpi_cs_n && rise && state == QCR_ST_WDATA && bit_cnt == 3'h7;
	assign en = chen[NCH-1:0];
	assign any_en = |en;
	assign sel = first_chan(en);

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = 1'b0;
		case (rx_byte)
			`QCR_CMD_TXTS | 8'h01: begin
				rd_byte = {tx_hwy_q[sel], txts_q[sel]};
				rd_ok = any_en; // RULE_14
			end
			`QCR_CMD_RXTS | 8'h01: begin
				rd_byte = {rpcm_q[sel], rxts_q[sel]};
				rd_ok = any_en; // RULE_14
			end
			`QCR_CMD_SLOT | 8'h01: begin
				rd_byte = {tab_q[sel], tx_edge_q, rx_cslot_q, tx_cslot_q};
				rd_ok = any_en; // RULE_05
			end
			`QCR_CMD_CFG | 8'h01: begin
				rd_byte = chip_cfg;
				rd_ok = 1'b1; // RULE_11
			end
			`QCR_CMD_CHEN | 8'h01: begin
				rd_byte = chen;
				rd_ok = 1'b1;
			end
			`QCR_CMD_RT, `QCR_CMD_RTC: begin
				rd_byte = rt_inputs;
				rd_ok = 1'b1; // RULE_16
			end
			`QCR_CMD_GAIN | 8'h01: begin
				rd_byte = gain_cfg[sel];
				rd_ok = any_en;
			end
			`QCR_CMD_IO | 8'h01: begin
				rd_byte = io_q[sel];
				rd_ok = any_en;
			end
			`QCR_CMD_DIR | 8'h01: begin
				// Clock-fail still reads with no channel selected
				rd_byte = {1'b0, active_q[sel] & any_en, clock_fail_in, dir_q[sel] & {5{any_en}}}; // RULE_22
				rd_ok = 1'b1;
			end
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Serial command framing
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Idle level of the serial clock, so release gives no false edge
			dclk_q <= 1'b1;
			state <= QCR_ST_CMD;
			bit_cnt <= 3'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			cmd_q <= 8'h00;
			mpi_dout <= 1'b0;
			mpi_dout_oe <= 1'b0;
		end else begin
			dclk_q <= mpi_dclk;
			if (mpi_cs_n) begin
				// Deselect aborts any partial byte
				state <= QCR_ST_CMD;
				bit_cnt <= 3'h0;
				mpi_dout_oe <= 1'b0;
			end else if (rise) begin
				bit_cnt <= bit_cnt + 3'h1;
				shift_in <= rx_byte;
				case (state)
					QCR_ST_CMD: begin
						if (bit_cnt == 3'h7) begin
							cmd_q <= rx_byte;
							if (is_wr_cmd(rx_byte)) begin
								state <= QCR_ST_WDATA;
							end else if (rd_ok) begin
								state <= QCR_ST_RDATA;
								shift_out <= rd_byte;
								mpi_dout <= rd_byte[7];
								mpi_dout_oe <= 1'b1;
							end
						end
					end
					QCR_ST_WDATA: begin
						if (bit_cnt == 3'h7) begin
							state <= QCR_ST_CMD;
						end
					end
					QCR_ST_RDATA: begin
						if (bit_cnt == 3'h7) begin
							state <= QCR_ST_CMD;
							mpi_dout_oe <= 1'b0;
						end
					end
					default: begin
						state <= QCR_ST_CMD;
					end
				endcase
			end else if (fall && state == QCR_ST_RDATA) begin
				mpi_dout <= shift_out[6];
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Global registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chip_cfg <= `QCR_RST_CFG; // RULE_11
			chen <= `QCR_RST_CHEN; // RULE_14
			tx_edge_q <= 1'b0;
			rx_cslot_q <= 3'h0;
			tx_cslot_q <= 3'h0;
		end else if (wr_done) begin
			case (cmd_q)
				`QCR_CMD_CFG: chip_cfg <= rx_byte; // RULE_08 RULE_11
				`QCR_CMD_CHEN: chen <= {1'b0, rx_byte[6:0]};
				`QCR_CMD_SLOT: begin
					if (any_en) begin // RULE_05
						tx_edge_q <= rx_byte[`QCR_BIT_TX_EDGE]; // RULE_03
						rx_cslot_q <= rx_byte[5:3]; // RULE_04
						tx_cslot_q <= rx_byte[2:0]; // RULE_04
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Per-channel registers
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic wr_ch;
			assign wr_ch = wr_done && en[ch]; // RULE_14

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					txts_q[ch] <= 7'(ch);
					rxts_q[ch] <= 7'(ch); // RULE_01
					tx_hwy_q[ch] <= 1'b0;
					rpcm_q[ch] <= 1'b0;
					tab_q[ch] <= 1'b0;
					gain_cfg[ch] <= `QCR_RST_GAIN;
					io_q[ch] <= `QCR_RST_IO;
					dir_q[ch] <= `QCR_RST_DIR; // RULE_21
				end else if (wr_ch) begin
					case (cmd_q)
						`QCR_CMD_TXTS: {tx_hwy_q[ch], txts_q[ch]} <= rx_byte;
						`QCR_CMD_RXTS: {rpcm_q[ch], rxts_q[ch]} <= rx_byte; // RULE_01
						`QCR_CMD_SLOT: tab_q[ch] <= rx_byte[`QCR_BIT_TAB]; // RULE_02
						`QCR_CMD_GAIN: gain_cfg[ch] <= rx_byte; // RULE_17
						`QCR_CMD_IO: io_q[ch] <= rx_byte; // RULE_19
						`QCR_CMD_DIR: dir_q[ch] <= rx_byte[4:0]; // RULE_21
						default: begin
						end
					endcase
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					active_q[ch] <= 1'b0;
				end else if (cmd_done && en[ch] && rx_byte == `QCR_CMD_ACT) begin
					active_q[ch] <= 1'b1; // RULE_23
				end else if (cmd_done && en[ch] && rx_byte == `QCR_CMD_DEACT) begin
					active_q[ch] <= 1'b0; // RULE_23
				end
			end

			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					line_pin_out[ch] <= 5'h00;
					line_pin_oe[ch] <= 5'h00;
					line_aux_out[ch] <= 2'h0;
					line_io_1_second[ch] <= 1'b0;
					rx_time_slot[ch] <= 7'h00;
					tx_time_slot[ch] <= 7'h00;
					tx_on_a[ch] <= 1'b0;
					tx_on_b[ch] <= 1'b0;
					analog_output_float[ch] <= 1'b0;
					analog_output_to_ref[ch] <= 1'b0;
					full_digital_loopback[ch] <= 1'b0;
					isn_cutoff[ch] <= 1'b0;
					channel_active_flag[ch] <= 1'b0;
				end else begin
					// Latch keeps every bit; direction only gates the driver
					line_pin_out[ch] <= {io_q[ch][4:2], io_q[ch][1:0]}; // RULE_19
					line_pin_oe[ch] <= dir_q[ch]; // RULE_19
					line_aux_out[ch] <= io_q[ch][7:6]; // RULE_20
					line_io_1_second[ch] <= io_q[ch][`QCR_BIT_LIO1B] & e1_mux_enable; // RULE_20
					rx_time_slot[ch] <= rxts_q[ch];
					tx_time_slot[ch] <= txts_q[ch];
					tx_on_a[ch] <= tab_q[ch] | ~tx_hwy_q[ch]; // RULE_02
					tx_on_b[ch] <= tab_q[ch] | tx_hwy_q[ch]; // RULE_02
					analog_output_float[ch] <= ~active_q[ch] & chen[`QCR_BIT_IDLE_FLOAT]; // RULE_13
					analog_output_to_ref[ch] <= ~active_q[ch] & ~chen[`QCR_BIT_IDLE_FLOAT]; // RULE_13
					full_digital_loopback[ch] <= gain_cfg[ch].impedance_scale_code == `QCR_ISN_MID; // RULE_18
					isn_cutoff[ch] <= gain_cfg[ch].impedance_scale_code == 5'h00; // RULE_18
					channel_active_flag[ch] <= active_q[ch]; // RULE_22
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Global outputs and clock decode
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_launch_edge <= 1'b0;
			rx_clock_slot <= 3'h0;
			tx_clock_slot <= 3'h0;
			robbed_bit_active <= 1'b0;
			e1_mux_allowed <= 1'b0;
			clock_sync_lost <= 1'b0;
			master_freq_khz <= 14'h0000;
			master_freq_reserved <= 1'b0;
		end else begin
			tx_launch_edge <= tx_edge_q; // RULE_03
			rx_clock_slot <= rx_cslot_q; // RULE_04
			tx_clock_slot <= tx_cslot_q; // RULE_04
			robbed_bit_active <= chen[`QCR_BIT_ROBBED] & mu_law_in; // RULE_12
			e1_mux_allowed <= chip_cfg.master_clock_source & e1_mux_enable; // RULE_09
			clock_sync_lost <= clock_fail_in; // RULE_22
			master_freq_reserved <= (chip_cfg.master_clock_freq[1:0] == 2'h3)
				|| (chip_cfg.master_clock_freq[3:2] == 2'h3); // RULE_10
			case (chip_cfg.master_clock_freq[1:0]) // RULE_10
				2'h0: master_freq_khz <= `QCR_KHZ_1536 << chip_cfg.master_clock_freq[3:2];
				2'h1: master_freq_khz <= `QCR_KHZ_1544 << chip_cfg.master_clock_freq[3:2];
				2'h2: master_freq_khz <= `QCR_KHZ_2048 << chip_cfg.master_clock_freq[3:2];
				default: master_freq_khz <= 14'h0000;
			endcase
			if (chip_cfg.master_clock_freq[3:2] == 2'h3) begin
				master_freq_khz <= 14'h0000; // RULE_10
			end
		end
	end

	// ----------------------------------------
	// Chopper divider from the 2048 kHz tick
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chop_cnt <= 3'h0;
			chopper_tick <= 1'b0;
		end else begin
			chopper_tick <= 1'b0;
			if (ref_2048_tick) begin
				if (chop_cnt >= (chip_cfg.chopper_rate_select ? `QCR_CHOP_DIV7 : `QCR_CHOP_DIV8)) begin // RULE_07
					chop_cnt <= 3'h0;
					chopper_tick <= 1'b1;
				end else begin
					chop_cnt <= chop_cnt + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Real-time interrupt
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rt_prev <= 8'h00;
			irq_pending <= 1'b0;
			irq_n_out <= 1'b1;
			irq_n_oe <= 1'b0;
		end else begin
			rt_prev <= rt_inputs;
			// A change seen in the clearing cycle keeps the interrupt pending
			if (rt_inputs != rt_prev) begin
				irq_pending <= 1'b1;
			end else if (cmd_done && rx_byte == `QCR_CMD_RTC) begin
				irq_pending <= 1'b0; // RULE_15
			end
			if (chip_cfg.irq_output_type) begin
				irq_n_out <= 1'b0; // RULE_06
				irq_n_oe <= irq_pending;
			end else begin
				irq_n_out <= ~irq_pending; // RULE_06
				irq_n_oe <= 1'b1;
			end
		end
	end

endmodule : qcr_regs

`default_nettype wire

// ===== hdl/qcr_map.svh
// Operation
// RULE_01: Each channel's receive slot holds 0..127, LSB at bit 0, resets to channel index.
// RULE_02: Both-highways bit clear uses highway select; set transmits on A and B.
// RULE_03: Global edge bit: 0 launches on falling PCM clock edge, 1 on rising.
// RULE_04: Global three-bit receive and transmit clock slots, 0..7, default 0.
// RULE_05: Edge and clock slot fields ignored on write and read unless a channel is enabled.
// RULE_06: Interrupt pin push-pull when type bit is 0, open-drain when 1 (default).
// RULE_07: Chopper clock is 2048 kHz divided by 8 when 0, by 7 when 1.
// RULE_08: Highway signalling bit off by default, enabled when 1.
// RULE_09: Clock source 0 uses clock pin, no E1 mux; 1 uses PCM clock, E1 mux allowed.
// RULE_10: Frequency code: base 1.536/1.544/2.048 MHz, x2 and x4 steps, reserved codes, default 1010.
// RULE_11: Chip configuration ignores channel enables and resets to 9Ah.
// RULE_12: Robbed-bit signalling active only when enabled and mu-law selected.
// RULE_13: Idle analog output to reference when 0, floating when 1, for deactivated channels.
// RULE_14: Per-channel enables gate channel commands; reset sets all four (0Fh).
// RULE_15: Real-time read 4Dh leaves interrupt, 4Fh also clears pending interrupt.
// RULE_16: Real-time byte holds A/B input bits per channel, readable regardless of enables.
// RULE_17: Gain bits select attenuator off, 6.02 dB gain and 6.02 dB loss when set.
// RULE_18: Impedance code gain is 0.0625*(code-16); code 16 loopback, code 0 cutoff.
// RULE_19: Output latch always stores; pin driven only when configured as output.
// RULE_20: Second line-1 output needs E1 mux mode; two top bits are output-only.
// RULE_21: Five direction bits, 1 output, 0 input; reset 00h makes all inputs.
// RULE_22: Status reports channel active and clock-fail; clock-fail ignores enables.
// RULE_23: Activate sets channel active flag; deactivate clears it.
`ifndef QCR_MAP_SVH
`define QCR_MAP_SVH

// ----------------------------------------
// Command codes (write code, read is code | 1)
// ----------------------------------------
`define QCR_CMD_DEACT 8'h00
`define QCR_CMD_ACT 8'h0E
`define QCR_CMD_TXTS 8'h40
`define QCR_CMD_RXTS 8'h42
`define QCR_CMD_SLOT 8'h44
`define QCR_CMD_CFG 8'h46
`define QCR_CMD_CHEN 8'h4A
`define QCR_CMD_RT 8'h4D
`define QCR_CMD_RTC 8'h4F
`define QCR_CMD_GAIN 8'h50
`define QCR_CMD_IO 8'h52
`define QCR_CMD_DIR 8'h54

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QCR_RST_SLOT 8'h00
`define QCR_RST_CFG 8'h9A
`define QCR_RST_CHEN 8'h0F
`define QCR_RST_GAIN 8'h00
`define QCR_RST_IO 8'h00
`define QCR_RST_DIR 5'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define QCR_BIT_TAB 7
`define QCR_BIT_TX_EDGE 6
`define QCR_BIT_ROBBED 6
`define QCR_BIT_IDLE_FLOAT 5
`define QCR_BIT_ACTIVE 6
`define QCR_BIT_CLK_LOST 5
`define QCR_BIT_LIO1B 5

// ----------------------------------------
// Clock figures in kHz, divider counts and impedance midpoint code
// ----------------------------------------
`define QCR_KHZ_1536 14'h0600
`define QCR_KHZ_1544 14'h0608
`define QCR_KHZ_2048 14'h0800
`define QCR_CHOP_DIV8 3'h7
`define QCR_CHOP_DIV7 3'h6
`define QCR_ISN_MID 5'h10

`endif

// ===== hdl/qcr_pkg.sv
package qcr_pkg;

	typedef struct packed {
		logic irq_output_type;
		logic chopper_rate_select;
		logic highway_signalling_on;
		logic master_clock_source;
		logic [3:0] master_clock_freq;
	} qcr_chip_cfg_s;

	typedef struct packed {
		logic input_atten_disable;
		logic tx_analog_boost;
		logic rx_analog_loss;
		logic [4:0] impedance_scale_code;
	} qcr_gain_s;

	typedef enum logic [1:0] {
		QCR_ST_CMD,
		QCR_ST_WDATA,
		QCR_ST_RDATA,
		QCR_ST_DONE
	} qcr_state_e;

endpackage : qcr_pkg

// ===== verification/qcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module qcr_regs_asserts
	import qcr_pkg::*;
#(
	parameter int NCH = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mpi_cs_n,
	input wire logic mpi_dout_oe,
	input wire logic clock_fail_in,
	input wire logic e1_mux_enable,
	input wire logic [NCH-1:0] line_io_1_second,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire qcr_chip_cfg_s chip_cfg,
	input wire logic master_freq_reserved,
	input wire qcr_gain_s [NCH-1:0] gain_cfg,
	input wire logic [NCH-1:0] isn_cutoff,
	input wire logic [NCH-1:0] channel_active_flag,
	input wire logic [NCH-1:0] analog_output_float,
	input wire logic [NCH-1:0] analog_output_to_ref,
	input wire logic clock_sync_lost
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Derived outputs lag one cycle, so relations wait until reset has aged
	logic [1:0] age;
	logic [NCH-1:0] cut;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			cut[i] = gain_cfg[i].impedance_scale_code == 5'h00;
		end
	end
	sequence s_oe_run;
		mpi_dout_oe [*8];
	endsequence
	sequence s_abort;
		##[0:7] mpi_cs_n;
	endsequence
	cs_quiet_a: assert property (mpi_cs_n && $past(mpi_cs_n) |-> !mpi_dout_oe)
		else $error("read data driven while deselected");
	read_run_a: assert property ($rose(mpi_dout_oe) |-> s_oe_run or s_abort)
		else $error("read byte cut short");
	irq_push_a: assert property (age == 2'h3 && $stable(chip_cfg) && !chip_cfg.irq_output_type |-> irq_n_oe)
		else $error("push-pull interrupt not driven");
	irq_drain_a: assert property (age == 2'h3 && $stable(chip_cfg) && chip_cfg.irq_output_type |-> !irq_n_out)
		else $error("open-drain interrupt drives high");
	freq_resv_a: assert property (age == 2'h3 |-> master_freq_reserved == ($past(chip_cfg.master_clock_freq[1:0]) == 2'h3
		|| $past(chip_cfg.master_clock_freq[3:2]) == 2'h3))
		else $error("reserved frequency flag wrong");
	e1_gate_a: assert property (age == 2'h3 && |line_io_1_second |-> $past(e1_mux_enable))
		else $error("second line output without mux mode");
	isn_cut_a: assert property (age == 2'h3 |-> isn_cutoff == $past(cut))
		else $error("cutoff flag does not follow code");
	idle_out_a: assert property (age == 2'h3 |-> (analog_output_float ^ analog_output_to_ref) == ~channel_active_flag
		&& (analog_output_float & analog_output_to_ref) == '0)
		else $error("idle output mode wrong");
	clk_lost_a: assert property ($rose(clock_fail_in) |-> ##[1:2] clock_sync_lost)
		else $error("clock fail not reported");
endmodule : qcr_regs_asserts
`default_nettype wire

// ===== verification/qcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module qcr_host (
	input wire logic clk,
	output logic mpi_cs_n,
	output logic mpi_dclk,
	output logic mpi_din,
	input wire logic mpi_dout,
	input wire logic mpi_dout_oe
);
	// Serial clock rests high between frames; data line flips once released
	initial begin
		mpi_cs_n = 1'b1;
		mpi_dclk = 1'b1;
		mpi_din = 1'b0;
	end
	// Phases of 3 low and 4 high cycles stay above the 2-cycle minimum
	task automatic bit_clk(input logic b);
		@(posedge clk);
		mpi_dclk <= 1'b0;
		mpi_din <= b;
		repeat (3) @(posedge clk);
		mpi_dclk <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : bit_clk
	// Mode 0 command only, 1 write, 2 read; drv low if any read bit was undriven
	task automatic xfer(input logic [7:0] c, input logic [7:0] d, input int m, output logic [7:0] q,
		output logic drv);
		q = 8'h00;
		drv = 1'b1;
		@(posedge clk);
		mpi_cs_n <= 1'b0;
		for (int i = 7; i >= 0; i--) bit_clk(c[i]);
		for (int i = 7; i >= 0 && m != 0; i--) begin
			if (m == 2) begin
				#1;
				// A released line floats; show the opposite level
				q[i] = mpi_dout_oe ? mpi_dout : ~mpi_dout;
				drv = drv & mpi_dout_oe;
			end
			bit_clk(d[i]);
		end
		@(posedge clk);
		mpi_cs_n <= 1'b1;
		mpi_din <= ~mpi_din;
		repeat (4) @(posedge clk);
	endtask : xfer
endmodule : qcr_host
`default_nettype wire

// ===== verification/test_qcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_qcr_regs
	import qcr_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mpi_cs_n, mpi_dclk, mpi_din, mpi_dout, mpi_dout_oe, drv;
	logic [7:0] rt_inputs = 8'h00;
	logic clock_fail_in = 1'b0;
	logic mu_law_in = 1'b0;
	logic e1_mux_enable = 1'b0;
	logic ref_2048_tick = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic [3:0][4:0] line_pin_out, line_pin_oe;
	logic [3:0][1:0] line_aux_out;
	logic [3:0] line_io_1_second, tx_on_a, tx_on_b, analog_output_float, analog_output_to_ref;
	logic [3:0] full_digital_loopback, isn_cutoff, channel_active_flag;
	logic irq_n_out, irq_n_oe, chopper_tick, master_freq_reserved, tx_launch_edge, robbed_bit_active, clock_sync_lost;
	logic [13:0] master_freq_khz;
	logic [2:0] rx_clock_slot, tx_clock_slot;
	logic [3:0][6:0] rx_time_slot, tx_time_slot;
	logic e1_mux_allowed;
	logic [7:0] rd;
	qcr_chip_cfg_s chip_cfg;
	qcr_gain_s [3:0] gain_cfg;
	int failures = 0;
	int checked = 0;
	qcr_regs #(.NCH(4)) dut (.clk, .sys_rst, .mpi_cs_n, .mpi_dclk, .mpi_din, .mpi_dout, .mpi_dout_oe, .rt_inputs,
		.clock_fail_in, .mu_law_in, .e1_mux_enable, .ref_2048_tick, .line_pin_in('0), .line_pin_out, .line_pin_oe,
		.line_aux_out, .line_io_1_second, .irq_n_out, .irq_n_oe, .chip_cfg, .chopper_tick, .master_freq_khz,
		.master_freq_reserved, .e1_mux_allowed, .tx_launch_edge, .rx_clock_slot, .tx_clock_slot, .rx_time_slot,
		.tx_time_slot, .tx_on_a, .tx_on_b, .robbed_bit_active, .analog_output_float, .analog_output_to_ref,
		.gain_cfg, .full_digital_loopback, .isn_cutoff, .channel_active_flag, .clock_sync_lost);
	qcr_host host (.clk, .mpi_cs_n, .mpi_dclk, .mpi_din, .mpi_dout, .mpi_dout_oe);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		tick_cnt <= tick_cnt + 2'h1;
		ref_2048_tick <= tick_cnt == 2'h3;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input int m = 1);
		host.xfer(c, d, m, rd, drv);
		#1;
	endtask : wr
	task automatic rdchk(input logic [7:0] c, input logic [7:0] e, input logic d = 1'b1);
		host.xfer(c, 8'h00, 2, rd, drv);
		#1;
		chk(drv, d);
		if (d) chk(rd, e);
	endtask : rdchk
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	function automatic logic [14:0] fexp(input logic [3:0] c);
		if (c[1:0] == 2'h3 || c[3:2] == 2'h3) return {1'b1, 14'h0000};
		return {1'b0, (c[1:0] == 2'h0 ? 14'h0600 : c[1:0] == 2'h1 ? 14'h0608 : 14'h0800) << c[3:2]};
	endfunction : fexp
	task automatic t_reset;
		logic [7:0] ra [6] = '{8'h45, 8'h47, 8'h4B, 8'h51, 8'h53, 8'h55};
		logic [7:0] rv [6] = '{8'h00, 8'h9A, 8'h0F, 8'h00, 8'h00, 8'h00};
		chk({tx_time_slot, rx_time_slot}, {2{7'h03, 7'h02, 7'h01, 7'h00}});
		chk({chip_cfg, master_freq_khz}, {8'h9A, 14'h2000});
		chk({tx_on_a, tx_on_b, analog_output_to_ref, isn_cutoff, full_digital_loopback}, 20'hF0FF0);
		chk({line_pin_oe, irq_n_oe, tx_launch_edge}, 0);
		for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
		$display("test reset done");
	endtask : t_reset
	task automatic t_slot;
		wr(8'h44, 8'hEB);
		chk({tx_launch_edge, rx_clock_slot, tx_clock_slot, tx_on_a, tx_on_b}, 15'h6BFF);
		wr(8'h4A, 8'h02);
		wr(8'h44, 8'h2B);
		chk({tx_launch_edge, tx_on_a, tx_on_b}, 9'h0FD);
		rdchk(8'h45, 8'h2B);
		wr(8'h4A, 8'h00);
		wr(8'h44, 8'hFF);
		chk(tx_launch_edge, 0);
		rdchk(8'h45, 8'h00, 1'b0);
		$display("test slot done");
	endtask : t_slot
	task automatic t_cfg;
		logic [3:0] n;
		logic [7:0] cfg;
		int k;
		for (int i = 0; i < 16; i++) begin
			n = i[3:0];
			cfg = {n[0], n[1], n[2], n[3], n};
			wr(8'h46, cfg);
			rdchk(8'h47, cfg);
			chk({chip_cfg, irq_n_oe}, {cfg, ~cfg[7]});
			chk({master_freq_reserved, master_freq_khz}, fexp(n));
		end
		for (int r = 0; r < 2; r++) begin
			wr(8'h46, {1'b1, r[0], 6'h1A});
			for (int j = 0; j < 80 && !chopper_tick; j++) settle();
			k = 0;
			for (int j = 0; j < 80; j++) begin
				@(posedge clk);
				#1;
				if (chopper_tick) break;
				k += ref_2048_tick;
			end
			chk(k, r ? 7 : 8);
		end
		wr(8'h46, 8'h9A);
		wr(8'h4A, 8'h0F);
		$display("test config done");
	endtask : t_cfg
	task automatic t_mode;
		wr(8'h4A, 8'h61);
		@(posedge clk) mu_law_in <= 1'b1;
		settle();
		chk({robbed_bit_active, analog_output_float, analog_output_to_ref}, 9'h1F0);
		@(posedge clk) mu_law_in <= 1'b0;
		settle();
		chk(robbed_bit_active, 0);
		wr(8'h0E, 8'h00, 0);
		chk({channel_active_flag, analog_output_float, analog_output_to_ref}, 12'h1E0);
		rdchk(8'h55, 8'h40);
		wr(8'h4A, 8'h0F);
		chk({robbed_bit_active, analog_output_float, analog_output_to_ref}, 9'h00E);
		wr(8'h00, 8'h00, 0);
		chk({channel_active_flag, analog_output_to_ref}, 8'h0F);
		$display("test mode done");
	endtask : t_mode
	task automatic t_rt;
		wr(8'h4A, 8'h00);
		@(posedge clk) rt_inputs <= 8'hA5;
		settle();
		wr(8'h46, 8'h1A);
		rdchk(8'h4D, 8'hA5);
		chk({irq_n_oe, irq_n_out}, 2'b10);
		rdchk(8'h4F, 8'hA5);
		chk({irq_n_oe, irq_n_out}, 2'b11);
		wr(8'h46, 8'h9A);
		@(posedge clk) rt_inputs <= 8'h5A;
		settle();
		chk({irq_n_oe, irq_n_out}, 2'b10);
		rdchk(8'h4F, 8'h5A);
		chk(irq_n_oe, 0);
		$display("test realtime done");
	endtask : t_rt
	task automatic t_gain;
		wr(8'h4A, 8'h04);
		wr(8'h50, 8'hF0);
		chk({gain_cfg, full_digital_loopback, isn_cutoff}, {8'h00, 8'hF0, 16'h0000, 8'h4B});
		rdchk(8'h51, 8'hF0);
		wr(8'h40, 8'hC5);
		wr(8'h42, 8'hFF);
		wr(8'h44, 8'h2B);
		chk({tx_time_slot, rx_time_slot}, {7'h03, 7'h45, 7'h01, 7'h00, 7'h03, 7'h7F, 7'h01, 7'h00});
		chk({tx_on_a, tx_on_b}, 8'hBD);
		rdchk(8'h43, 8'hFF);
		wr(8'h4A, 8'h0F);
		wr(8'h50, 8'h05);
		chk({gain_cfg, isn_cutoff}, {32'h05050505, 4'h0});
		$display("test gain done");
	endtask : t_gain
	task automatic t_io;
		wr(8'h54, 8'h65);
		wr(8'h52, 8'hFF);
		chk(line_pin_oe, {4{5'h05}});
		chk({line_pin_out, line_aux_out, line_io_1_second}, {{4{5'h1F}}, 8'hFF, 4'h0});
		@(posedge clk) e1_mux_enable <= 1'b1;
		settle();
		chk({line_io_1_second, e1_mux_allowed}, 5'h1F);
		rdchk(8'h53, 8'hFF);
		rdchk(8'h55, 8'h05);
		@(posedge clk) clock_fail_in <= 1'b1;
		wr(8'h4A, 8'h00);
		rdchk(8'h55, 8'h20);
		chk(clock_sync_lost, 1);
		wr(8'h46, 8'h8A);
		chk(e1_mux_allowed, 0);
		$display("test io done");
	endtask : t_io
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		settle();
		t_reset();
		t_slot();
		t_cfg();
		t_mode();
		t_rt();
		t_gain();
		t_io();
		report_and_stop();
	end
	// Whole run is near 10k cycles; a 50k-cycle bound leaves ample margin
	initial begin
		#1000000;
		failures++;
		report_and_stop();
	end
endmodule : test_qcr_regs
bind qcr_regs qcr_regs_asserts #(.NCH(NCH)) chk_i (.clk, .sys_rst, .mpi_cs_n, .mpi_dout_oe, .clock_fail_in,
	.e1_mux_enable, .line_io_1_second, .irq_n_out, .irq_n_oe, .chip_cfg, .master_freq_reserved, .gain_cfg,
	.isn_cutoff, .channel_active_flag, .analog_output_float, .analog_output_to_ref, .clock_sync_lost);
`default_nettype wire
